/* File: hw/sfs_config.sv */
// Behaviour
// - format 0 writes nothing; undefined codes reserved
// - format 1: one 16-bit word
// - format 2: one 32-bit word
// - format 3: 16-bit sample plus background, integration mode only
// - format 4: 32-bit pair or four 16-bit
// - format 6: four 32-bit channels, non-integration
// - slot enable bit 0 activates slot
// - bit 14 picks internal or external trigger
// - bit 8 zero: internal oscillator clock
// - bit 8 one: clock from shared pin
`timescale 1ns/100ps
module sfs_config (
   input wire logic mclk,
   input wire logic rst_n,
   input wire sfs_pkg::sfs_reg_req_s reg_req,
   output logic [15:0] reg_rdata,
   input wire logic dig_int_mode,
   input wire logic internal_tick,
   input wire logic ext_trigger_pin,
   input wire logic osc_tick,
   input wire logic shared_photodiode_output_pin,
   output logic sample_start,
   output logic sample_clk_tick,
   output logic first_slot_enable,
   output logic external_trigger_enable,
   output logic slow_oscillator_bypass,
   output logic fifo_req,
   output sfs_pkg::sfs_fifo_fmt_s fifo_fmt
);
   logic [15:0] slot_cfg_ff;
   logic [15:0] trig_src_ff;
   logic [15:0] clk_ctrl_ff;
   logic [15:0] rdata_ff;
   logic fifo_req_ff;
   sfs_pkg::sfs_fifo_fmt_s fmt_ff;

   logic ext_rise;
   logic pd_rise;

   sfs_sync_edge u_ext_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .pin_in(ext_trigger_pin),
      .level_o(),
      .rise_o(ext_rise)
   );

   sfs_sync_edge u_pd_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .pin_in(shared_photodiode_output_pin),
      .level_o(),
      .rise_o(pd_rise)
   );

   // register decode
   wire sel_slot = reg_req.addr == sfs_pkg::SLOT_CFG_ADDR;
   wire sel_trig = reg_req.addr == sfs_pkg::TRIG_SRC_ADDR;
   wire sel_clk = reg_req.addr == sfs_pkg::CLK_CTRL_ADDR;
   wire wr_slot = reg_req.wr & sel_slot;
   wire wr_trig = reg_req.wr & sel_trig;
   wire wr_clk = reg_req.wr & sel_clk;

   // reserved bits are stored as written; the host keeps them at their
   // documented values, so no masking is applied here
   wire [15:0] nxt_slot_cfg = wr_slot ? reg_req.wdata : slot_cfg_ff;
   wire [15:0] nxt_trig_src = wr_trig ? reg_req.wdata : trig_src_ff;
   wire [15:0] nxt_clk_ctrl = wr_clk ? reg_req.wdata : clk_ctrl_ff;
   wire [15:0] rd_mux = sel_slot ? slot_cfg_ff :
                        sel_trig ? trig_src_ff :
                        sel_clk ? clk_ctrl_ff : sfs_pkg::UNMAPPED_RDATA;
   wire [15:0] nxt_rdata = reg_req.rd ? rd_mux : rdata_ff;

   wire [2:0] first_slot_fifo_format = slot_cfg_ff[sfs_pkg::FMT_MSB:sfs_pkg::FMT_LSB];
   wire slot_on = slot_cfg_ff[sfs_pkg::SLOT_EN_BIT];
   wire ext_on = trig_src_ff[sfs_pkg::EXT_TRIG_BIT];
   wire byp_on = clk_ctrl_ff[sfs_pkg::OSC_BYP_BIT];

   // trigger source mux; internal ticks are ignored while external is chosen
   wire start = ext_on ? ext_rise : internal_tick;
   // sample clock source; pin edges are ignored while the oscillator runs
   wire clk_tick = byp_on ? pd_rise : osc_tick;

   // second-slot gating against averaging is the host's job, not checked here
   wire sfs_pkg::sfs_fifo_fmt_s fmt_dec =
      sfs_pkg::sfs_decode_fmt(first_slot_fifo_format, dig_int_mode);
   wire nxt_fifo_req = start & slot_on & fmt_dec.writes;
   wire sfs_pkg::sfs_fifo_fmt_s nxt_fmt = nxt_fifo_req ? fmt_dec : fmt_ff;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         slot_cfg_ff <= sfs_pkg::SLOT_CFG_RST;
         trig_src_ff <= sfs_pkg::TRIG_SRC_RST;
         clk_ctrl_ff <= sfs_pkg::CLK_CTRL_RST;
         rdata_ff <= sfs_pkg::UNMAPPED_RDATA;
         fifo_req_ff <= 1'b0;
         fmt_ff <= '0;
      end else begin
         slot_cfg_ff <= nxt_slot_cfg;
         trig_src_ff <= nxt_trig_src;
         clk_ctrl_ff <= nxt_clk_ctrl;
         rdata_ff <= nxt_rdata;
         fifo_req_ff <= nxt_fifo_req;
         fmt_ff <= nxt_fmt;
      end
   end

   assign reg_rdata = rdata_ff;
   assign sample_start = start;
   assign sample_clk_tick = clk_tick;
   assign first_slot_enable = slot_on;
   assign external_trigger_enable = ext_on;
   assign slow_oscillator_bypass = byp_on;
   assign fifo_req = fifo_req_ff;
   assign fifo_fmt = fmt_ff;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_start_code(logic [2:0] c);
      start && slot_on && first_slot_fifo_format == c;
   endsequence

   a_fmt_none_silent: assert property (s_start_code(sfs_pkg::FMT_NONE) |=> !fifo_req)
      else $error("format 0 produced a fifo request");
   a_fmt_reserved_silent: assert property ((start && slot_on && fmt_dec.reserved)
      |=> !fifo_req)
      else $error("reserved format produced a fifo request");
   a_fmt_one16: assert property (s_start_code(sfs_pkg::FMT_ONE16)
      |=> fifo_req && fifo_fmt.words == 3'h1 && !fifo_fmt.word32)
      else $error("format 1 not one 16-bit word");
   a_fmt_one32: assert property (s_start_code(sfs_pkg::FMT_ONE32)
      |=> fifo_req && fifo_fmt.words == 3'h1 && fifo_fmt.word32)
      else $error("format 2 not one 32-bit word");
   a_fmt_bg16: assert property ((s_start_code(sfs_pkg::FMT_BG16) and dig_int_mode)
      |=> fifo_req && fifo_fmt.background && !fifo_fmt.word32 && fifo_fmt.words == 3'h2)
      else $error("format 3 not sample plus 16-bit background");
   a_fmt_pair_int: assert property ((s_start_code(sfs_pkg::FMT_PAIR) and dig_int_mode)
      |=> fifo_req && fifo_fmt.background && fifo_fmt.word32 && fifo_fmt.words == 3'h2)
      else $error("format 4 not 32-bit sample plus background");
   a_fmt_pair_quad: assert property ((s_start_code(sfs_pkg::FMT_PAIR) and !dig_int_mode)
      |=> fifo_req && fifo_fmt.per_channel && !fifo_fmt.word32 && fifo_fmt.words == 3'h4)
      else $error("format 4 not four 16-bit channels");
   a_fmt_ch32_mode: assert property ((s_start_code(sfs_pkg::FMT_CH32) and !dig_int_mode)
      |=> fifo_req && fifo_fmt.per_channel && fifo_fmt.word32 && fifo_fmt.words == 3'h4)
      else $error("format 6 not four 32-bit channels");
   a_slot_enable_write: assert property (wr_slot |=> first_slot_enable ==
      $past(reg_req.wdata[sfs_pkg::SLOT_EN_BIT]))
      else $error("slot enable did not follow the write");
   a_slot_off_quiet: assert property (!first_slot_enable |=> !fifo_req)
      else $error("fifo request with slot disabled");
   a_trig_internal: assert property ((!external_trigger_enable && internal_tick)
      |-> sample_start)
      else $error("internal tick did not start a sample");
   a_trig_external: assert property ((external_trigger_enable && !ext_rise)
      |-> !sample_start)
      else $error("sample started without an external edge");
   a_clk_source: assert property (sample_clk_tick ==
      (slow_oscillator_bypass ? pd_rise : osc_tick))
      else $error("sample clock taken from the wrong source");
   a_bypass_write: assert property (wr_clk |=> slow_oscillator_bypass ==
      $past(reg_req.wdata[8]))
      else $error("bypass bit did not follow the write");
endmodule

/* File: hw/sfs_sync_edge.sv */
`timescale 1ns/100ps
module sfs_sync_edge (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pin_in,
   output logic level_o,
   output logic rise_o
);
   logic meta_ff;
   logic sync_ff;
   logic last_ff;
   logic rise_ff;
   wire nxt_rise = sync_ff & ~last_ff;

   // meta_ff feeds sync_ff only
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
         rise_ff <= 1'b0;
      end else begin
         meta_ff <= pin_in;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
         rise_ff <= nxt_rise;
      end
   end

   assign level_o = sync_ff;
   assign rise_o = rise_ff;
endmodule

/* File: shared/sfs_pkg.sv */
package sfs_pkg;

   // register indices on the internal register port
   localparam logic [7:0] SLOT_CFG_ADDR = 8'h11;
   localparam logic [7:0] TRIG_SRC_ADDR = 8'h38;
   localparam logic [7:0] CLK_CTRL_ADDR = 8'h4b;

   // reset values
   localparam logic [15:0] SLOT_CFG_RST = 16'h1000;
   localparam logic [15:0] TRIG_SRC_RST = 16'h0000;
   localparam logic [15:0] CLK_CTRL_RST = 16'h2612;
   localparam logic [15:0] UNMAPPED_RDATA = 16'h0000;

   // field positions
   localparam int SLOT_EN_BIT = 0;
   localparam int FMT_LSB = 2;
   localparam int FMT_MSB = 4;
   localparam int EXT_TRIG_BIT = 14;
   localparam int OSC_BYP_BIT = 8;

   // first-slot fifo format codes
   localparam logic [2:0] FMT_NONE = 3'h0;
   localparam logic [2:0] FMT_ONE16 = 3'h1;
   localparam logic [2:0] FMT_ONE32 = 3'h2;
   localparam logic [2:0] FMT_BG16 = 3'h3;
   localparam logic [2:0] FMT_PAIR = 3'h4;
   localparam logic [2:0] FMT_CH32 = 3'h6;

   localparam logic [2:0] WORDS_NONE = 3'h0;
   localparam logic [2:0] WORDS_ONE = 3'h1;
   localparam logic [2:0] WORDS_TWO = 3'h2;
   localparam logic [2:0] WORDS_FOUR = 3'h4;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } sfs_reg_req_s;

   typedef struct packed {
      logic writes;       // a sample of this slot goes into the fifo
      logic reserved;     // code not defined for the current integration mode
      logic [2:0] words;  // words stored per sample
      logic word32;       // each word is 32 bits, else 16
      logic background;   // second word is the background value
      logic per_channel;  // one word per channel instead of a sum
   } sfs_fifo_fmt_s;

   function automatic sfs_fifo_fmt_s sfs_decode_fmt(input logic [2:0] code,
                                                    input logic dig_int);
      sfs_fifo_fmt_s f;
      f = '0;
      case (code)
         FMT_NONE: begin
         end
         FMT_ONE16: begin
            f.words = WORDS_ONE;
         end
         FMT_ONE32: begin
            f.words = WORDS_ONE;
            f.word32 = 1'b1;
         end
         FMT_BG16: begin
            if (dig_int) begin
               f.words = WORDS_TWO;
               f.background = 1'b1;
            end else begin
               f.reserved = 1'b1;
            end
         end
         FMT_PAIR: begin
            if (dig_int) begin
               f.words = WORDS_TWO;
               f.word32 = 1'b1;
               f.background = 1'b1;
            end else begin
               f.words = WORDS_FOUR;
               f.per_channel = 1'b1;
            end
         end
         FMT_CH32: begin
            if (!dig_int) begin
               f.words = WORDS_FOUR;
               f.word32 = 1'b1;
               f.per_channel = 1'b1;
            end else begin
               f.reserved = 1'b1;
            end
         end
         default: begin
            f.reserved = 1'b1;
         end
      endcase
      f.writes = (f.words != WORDS_NONE);
      return f;
   endfunction

endpackage

/* File: tb/sfs_config_bench.sv */
`timescale 1ns/100ps
module sfs_config_bench;
   logic mclk, rst_n, dig_int_mode, internal_tick, ext_trigger_pin, osc_tick;
   logic shared_photodiode_output_pin, sample_start, sample_clk_tick, fifo_req;
   logic first_slot_enable, external_trigger_enable, slow_oscillator_bypass;
   logic [15:0] reg_rdata;
   sfs_pkg::sfs_reg_req_s reg_req;
   sfs_pkg::sfs_fifo_fmt_s fifo_fmt, exp_fmt;
   int miscompares, comparisons, n;

   sfs_config dut_u (.mclk(mclk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .dig_int_mode(dig_int_mode), .internal_tick(internal_tick),
      .ext_trigger_pin(ext_trigger_pin), .osc_tick(osc_tick),
      .shared_photodiode_output_pin(shared_photodiode_output_pin),
      .sample_start(sample_start), .sample_clk_tick(sample_clk_tick),
      .first_slot_enable(first_slot_enable), .external_trigger_enable(external_trigger_enable),
      .slow_oscillator_bypass(slow_oscillator_bypass), .fifo_req(fifo_req), .fifo_fmt(fifo_fmt));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic report_and_stop;
      $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one idle cycle between requests keeps every strobe change in its own time step
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      #1 reg_req.wr = 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge mclk);
      #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge mclk);
      #1 reg_req.rd = 1'b0;
      chk(reg_rdata, exp);
   endtask

   // internal tick: sample_start follows it only while the internal source is chosen
   task automatic tick_chk(input logic exp_start, input logic exp_req);
      @(posedge mclk);
      #1 internal_tick = 1'b1;
      #1 chk(16'(sample_start), 16'(exp_start));
      @(posedge mclk);
      #1 internal_tick = 1'b0;
      chk(16'(fifo_req), 16'(exp_req));
   endtask

   // raise one pin and count edges until its pulse shows; three edges of synchroniser
   task automatic pin_rise(input bit sel);
      @(posedge mclk);
      #1 if (sel) shared_photodiode_output_pin = 1'b1;
      else ext_trigger_pin = 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         #1 n++;
      end while (!(sel ? sample_clk_tick : sample_start) && n < 6);
      if (n == 6) begin
         miscompares++;
         report_and_stop();
      end
      chk(16'(n), 16'd3);
      @(posedge mclk);
      #1 shared_photodiode_output_pin = 1'b0;
      ext_trigger_pin = 1'b0;
      if (!sel) chk(16'(fifo_req), 16'd1);
   endtask

   initial begin
      #200000 miscompares++;
      report_and_stop();
   end

   initial begin
      miscompares = 0;
      comparisons = 0;
      rst_n = 1'b0;
      reg_req = '0;
      {dig_int_mode, internal_tick, ext_trigger_pin, osc_tick} = 4'h0;
      shared_photodiode_output_pin = 1'b0;
      repeat (16) @(posedge mclk);
      #1 rst_n = 1'b1;
      rd_chk(sfs_pkg::SLOT_CFG_ADDR, sfs_pkg::SLOT_CFG_RST);
      rd_chk(sfs_pkg::TRIG_SRC_ADDR, sfs_pkg::TRIG_SRC_RST);
      rd_chk(sfs_pkg::CLK_CTRL_ADDR, sfs_pkg::CLK_CTRL_RST);
      rd_chk(8'h12, sfs_pkg::UNMAPPED_RDATA);
      // every code in both integration modes; expectations built from the format table
      for (int d = 0; d < 2; d++) begin
         for (int c = 0; c < 8; c++) begin
            dig_int_mode = d[0];
            wr_reg(sfs_pkg::SLOT_CFG_ADDR, 16'h1001 | 16'(c << 2));
            exp_fmt = '0;
            exp_fmt.words = (c == 1 || c == 2) ? 3'h1 : (c == 3 && d == 1) ? 3'h2 :
                            (c == 4) ? (d == 1 ? 3'h2 : 3'h4) : (c == 6 && d == 0) ? 3'h4 : 3'h0;
            exp_fmt.word32 = c == 2 || (c == 4 && d == 1) || (c == 6 && d == 0);
            exp_fmt.background = (c == 3 || c == 4) && d == 1;
            exp_fmt.per_channel = (c == 4 || c == 6) && d == 0;
            exp_fmt.writes = exp_fmt.words != 3'h0;
            tick_chk(1'b1, exp_fmt.writes);
            if (exp_fmt.writes) chk(16'(fifo_fmt), 16'(exp_fmt));
         end
      end
      wr_reg(sfs_pkg::SLOT_CFG_ADDR, 16'h1004);
      chk(16'(first_slot_enable), 16'd0);
      tick_chk(1'b1, 1'b0);
      wr_reg(sfs_pkg::SLOT_CFG_ADDR, 16'h1005);
      chk(16'(first_slot_enable), 16'd1);
      wr_reg(sfs_pkg::TRIG_SRC_ADDR, 16'h4000);
      chk(16'(external_trigger_enable), 16'd1);
      tick_chk(1'b0, 1'b0);
      pin_rise(1'b0);
      @(posedge mclk);
      #1 osc_tick = 1'b1;
      #1 chk(16'(sample_clk_tick), 16'd1);
      @(posedge mclk);
      #1 osc_tick = 1'b0;
      wr_reg(sfs_pkg::CLK_CTRL_ADDR, 16'h2712);
      chk(16'(slow_oscillator_bypass), 16'd1);
      @(posedge mclk);
      #1 osc_tick = 1'b1;
      #1 chk(16'(sample_clk_tick), 16'd0);
      @(posedge mclk);
      #1 osc_tick = 1'b0;
      pin_rise(1'b1);
      rd_chk(sfs_pkg::CLK_CTRL_ADDR, 16'h2712);
      rd_chk(sfs_pkg::TRIG_SRC_ADDR, 16'h4000);
      // a second reset in mid-run must bring the reset values back
      @(posedge mclk);
      #1 rst_n = 1'b0;
      @(posedge mclk);
      #1 rst_n = 1'b1;
      rd_chk(sfs_pkg::SLOT_CFG_ADDR, sfs_pkg::SLOT_CFG_RST);
      chk(16'(slow_oscillator_bypass), 16'd0);
      chk(16'(external_trigger_enable), 16'd0);
      chk(16'(fifo_fmt), 16'h0000);
      report_and_stop();
   end
endmodule
